// File: pkg/bcc_regs.svh
`ifndef BCC_REGS_SVH
`define BCC_REGS_SVH

// word indices; byte address is four times the index
`define BCC_IDX_SEC_MIN     6'h12
`define BCC_IDX_HOUR_DAY    6'h13
`define BCC_IDX_MON_YEAR    6'h14
`define BCC_IDX_WDAY_CTL    6'h15

// control bit positions in the weekday/control word
`define BCC_BIT_ROUND       13
`define BCC_BIT_HALT        14
`define BCC_BIT_LOAD        15

// field reset values (BCD)
`define BCC_RST_SEC         8'h00
`define BCC_RST_MIN         8'h00
`define BCC_RST_HOUR        8'h00
`define BCC_RST_DAY         8'h01
`define BCC_RST_MON         8'h01
`define BCC_RST_YEAR        8'h00
`define BCC_RST_WDAY        8'h00
`define BCC_RST_HALT        1'b0

// field limits (BCD)
`define BCC_MAX_SEC         8'h59
`define BCC_MAX_MIN         8'h59
`define BCC_MAX_HOUR        8'h23
`define BCC_MAX_MON         8'h12
`define BCC_MAX_YEAR        8'h99
`define BCC_MAX_WDAY        8'h06
`define BCC_MIN_DAY         8'h01
`define BCC_MIN_MON         8'h01
`define BCC_ZERO            8'h00
`define BCC_ROUND_UP_FROM   8'h30

// time base
`define BCC_TICK_PERIOD_S   1
`define BCC_CLK_HZ          200000000
`define BCC_TICK_CYCLES     (`BCC_TICK_PERIOD_S * `BCC_CLK_HZ)

`endif

// File: pkg/bcc_pkg.sv
`default_nettype none

package bcc_pkg;

  // bus answer sequencer, one-hot
  typedef enum logic [1:0] {
    BCC_BUS_IDLE = 2'b01,
    BCC_BUS_ACK  = 2'b10
  } bcc_bus_state_t;

  typedef logic [7:0] bcc_bcd_t;

endpackage

`default_nettype wire

// File: rtl/bcc_tick_div.sv
`default_nettype none

module bcc_tick_div #(
  parameter int unsigned CYCLES = 200000000
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // control
  input  wire logic enable,
  input  wire logic restart,
  // one-cycle pulse per period
  output logic      tick
);

  logic [31:0] cnt_q;

  always_ff @(posedge clk) begin
    if (!rstn || restart || !enable) begin
      cnt_q <= 32'h0000_0000;
    end else if (cnt_q == 32'(CYCLES - 1)) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  assign tick = enable && !restart && (cnt_q == 32'(CYCLES - 1));

endmodule

`default_nettype wire

// File: rtl/bcc_bcd_inc.sv
`default_nettype none

module bcc_bcd_inc (
  // present value and limits
  input  wire logic [7:0] val,
  input  wire logic [7:0] lo,
  input  wire logic [7:0] hi,
  // next value and wrap
  output logic [7:0]      nxt,
  output logic            wrap
);

  // values at or beyond the limit also wrap, so a bad load recovers
  always_comb begin
    wrap = (val >= hi);
    if (wrap) begin
      nxt = lo;
    end else if (val[3:0] >= 4'h9) begin
      nxt = {val[7:4] + 4'h1, 4'h0};
    end else begin
      nxt = {val[7:4], val[3:0] + 4'h1};
    end
  end

endmodule

`default_nettype wire

// File: rtl/bcc_calendar.sv
`include "bcc_regs.svh"
`default_nettype none

// Functional notes
// [R1] count while halt clear, freeze while set
// [R2] word one: seconds low, minutes high, 00-59
// [R3] word two low byte: hours 00-23
// [R4] word two high: day, month-length and leap aware
// [R5] word three low byte: month 1-12
// [R6] word three high byte: year 00-99
// [R7] word four low: weekday 0-6, daily step
// [R8] round: clear seconds, carry if thirty up
// [R9] operator halts before loading fields
// [R10] operator writes only valid in-range BCD
// [R11] operator may write halt plus weekday together
// [R12] load bit resumes and clears load, halt
// [R13] fields and control bits visible every cycle
// [R14] one-second carry chain through all fields
// [R15] divider tick; halted writes stored untouched
module bcc_calendar #(
  parameter int unsigned TICK_CYCLES = `BCC_TICK_CYCLES,
  parameter int unsigned ADDR_W      = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic [31:0]            readdata,
  output logic                   waitrequest,
  // calendar fields
  output logic [7:0]             sec_bcd,
  output logic [7:0]             min_bcd,
  output logic [7:0]             hour_bcd,
  output logic [7:0]             day_bcd,
  output logic [7:0]             mon_bcd,
  output logic [7:0]             year_bcd,
  output logic [7:0]             wday_bcd,
  // control state
  output logic                   halted,
  output logic                   sec_tick
);

  localparam int NF = 7;
  localparam int F_SEC  = 0;
  localparam int F_MIN  = 1;
  localparam int F_HOUR = 2;
  localparam int F_DAY  = 3;
  localparam int F_MON  = 4;
  localparam int F_YEAR = 5;
  localparam int F_WDAY = 6;

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  bcc_pkg::bcc_bus_state_t bus_q;
  bcc_pkg::bcc_bus_state_t bus_d;
  logic [31:0]             rdata_q;
  logic                    req;
  logic                    acc_wr;
  logic [5:0]              word_idx;
  logic [3:0]              word_sel;
  logic                    addr_ok;

  assign req      = read || write;
  assign word_idx = address[7:2];
  assign addr_ok  = (address[1:0] == 2'h0);

  assign word_sel[0] = addr_ok && (word_idx == `BCC_IDX_SEC_MIN);
  assign word_sel[1] = addr_ok && (word_idx == `BCC_IDX_HOUR_DAY);
  assign word_sel[2] = addr_ok && (word_idx == `BCC_IDX_MON_YEAR);
  assign word_sel[3] = addr_ok && (word_idx == `BCC_IDX_WDAY_CTL);

  // one wait state: answer on the second edge of every request
  always_comb begin
    case (bus_q)
      bcc_pkg::BCC_BUS_IDLE: bus_d = req ? bcc_pkg::BCC_BUS_ACK : bcc_pkg::BCC_BUS_IDLE;
      bcc_pkg::BCC_BUS_ACK:  bus_d = bcc_pkg::BCC_BUS_IDLE;
      default:               bus_d = bcc_pkg::BCC_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      bus_q <= bcc_pkg::BCC_BUS_IDLE;
    end else begin
      bus_q <= bus_d;
    end
  end

  assign waitrequest = req && (bus_q != bcc_pkg::BCC_BUS_ACK);
  assign acc_wr      = write && (bus_q == bcc_pkg::BCC_BUS_ACK);
  assign readdata    = rdata_q;

  // ------------------------------------------------------------
  // field and control storage
  // ------------------------------------------------------------
  logic [7:0] fld_q   [NF];
  logic [7:0] fld_inc [NF];
  logic [7:0] fld_lo  [NF];
  logic [7:0] fld_hi  [NF];
  logic [NF-1:0] wrap;
  logic [NF-1:0] adv;
  logic [NF-1:0] wr_fld;

  logic round_q;
  logic halt_q;
  logic load_q;
  logic run;
  logic tick;
  logic do_round;
  logic round_carry;
  logic [7:0] day_max;
  logic leap;

  assign run = !halt_q; // [R1]

  // ------------------------------------------------------------
  // time base
  // ------------------------------------------------------------
  // restart on load so the first second after a set is full length
  bcc_tick_div #(
    .CYCLES (TICK_CYCLES)
  ) u_div (
    .clk     (clk),
    .rstn    (rstn),
    .enable  (run),
    .restart (load_q),
    .tick    (tick)
  ); // [R15]

  assign sec_tick = tick;

  // ------------------------------------------------------------
  // month length
  // ------------------------------------------------------------
  // two-digit year: divisible by four from the BCD digits
  always_comb begin
    if (!fld_q[F_YEAR][4]) begin
      leap = (fld_q[F_YEAR][3:0] == 4'h0) ||
             (fld_q[F_YEAR][3:0] == 4'h4) ||
             (fld_q[F_YEAR][3:0] == 4'h8);
    end else begin
      leap = (fld_q[F_YEAR][3:0] == 4'h2) ||
             (fld_q[F_YEAR][3:0] == 4'h6);
    end
  end

  always_comb begin
    case (fld_q[F_MON])
      8'h02:   day_max = leap ? 8'h29 : 8'h28;
      8'h04:   day_max = 8'h30;
      8'h06:   day_max = 8'h30;
      8'h09:   day_max = 8'h30;
      8'h11:   day_max = 8'h30;
      default: day_max = 8'h31;
    endcase
  end // [R4]

  // ------------------------------------------------------------
  // limits per field
  // ------------------------------------------------------------
  always_comb begin
    fld_lo[F_SEC]  = `BCC_ZERO;
    fld_hi[F_SEC]  = `BCC_MAX_SEC; // [R2]
    fld_lo[F_MIN]  = `BCC_ZERO;
    fld_hi[F_MIN]  = `BCC_MAX_MIN; // [R2]
    fld_lo[F_HOUR] = `BCC_ZERO;
    fld_hi[F_HOUR] = `BCC_MAX_HOUR; // [R3]
    fld_lo[F_DAY]  = `BCC_MIN_DAY;
    fld_hi[F_DAY]  = day_max; // [R4]
    fld_lo[F_MON]  = `BCC_MIN_MON;
    fld_hi[F_MON]  = `BCC_MAX_MON; // [R5]
    fld_lo[F_YEAR] = `BCC_ZERO;
    fld_hi[F_YEAR] = `BCC_MAX_YEAR; // [R6]
    fld_lo[F_WDAY] = `BCC_ZERO;
    fld_hi[F_WDAY] = `BCC_MAX_WDAY; // [R7]
  end

  // ------------------------------------------------------------
  // round-off
  // ------------------------------------------------------------
  assign do_round    = round_q && run;
  assign round_carry = do_round && (fld_q[F_SEC] >= `BCC_ROUND_UP_FROM); // [R8]

  // ------------------------------------------------------------
  // carry chain
  // ------------------------------------------------------------
  always_comb begin
    adv[F_SEC]  = tick && !do_round;
    adv[F_MIN]  = (tick && wrap[F_SEC]) || round_carry; // [R8]
    adv[F_HOUR] = adv[F_MIN] && wrap[F_MIN];
    adv[F_DAY]  = adv[F_HOUR] && wrap[F_HOUR];
    adv[F_MON]  = adv[F_DAY] && wrap[F_DAY];
    adv[F_YEAR] = adv[F_MON] && wrap[F_MON];
    adv[F_WDAY] = adv[F_HOUR] && wrap[F_HOUR]; // [R7]
  end // [R14]

  // ------------------------------------------------------------
  // per-field increment and write decode
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NF; gi++) begin : g_fld
      bcc_bcd_inc u_inc (
        .val  (fld_q[gi]),
        .lo   (fld_lo[gi]),
        .hi   (fld_hi[gi]),
        .nxt  (fld_inc[gi]),
        .wrap (wrap[gi])
      ); // [R14]

      assign wr_fld[gi] = acc_wr && word_sel[gi / 2] && byteenable[gi % 2];

      // a bus write wins over counting in the same cycle
      always_ff @(posedge clk) begin
        if (!rstn) begin
          case (gi)
            F_SEC:   fld_q[gi] <= `BCC_RST_SEC;
            F_MIN:   fld_q[gi] <= `BCC_RST_MIN;
            F_HOUR:  fld_q[gi] <= `BCC_RST_HOUR;
            F_DAY:   fld_q[gi] <= `BCC_RST_DAY;
            F_MON:   fld_q[gi] <= `BCC_RST_MON;
            F_YEAR:  fld_q[gi] <= `BCC_RST_YEAR;
            default: fld_q[gi] <= `BCC_RST_WDAY;
          endcase
        end else if (wr_fld[gi]) begin
          fld_q[gi] <= writedata[(gi % 2) * 8 +: 8]; // [R15]
        end else if (gi == F_SEC && do_round) begin
          fld_q[gi] <= `BCC_ZERO; // [R8]
        end else if (adv[gi]) begin
          fld_q[gi] <= fld_inc[gi]; // [R1]
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // control bits
  // ------------------------------------------------------------
  logic wr_ctl;

  assign wr_ctl = acc_wr && word_sel[3] && byteenable[1];

  // software set wins over the self-clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      halt_q <= `BCC_RST_HALT;
    end else if (wr_ctl) begin
      halt_q <= writedata[`BCC_BIT_HALT]; // [R1]
    end else if (load_q) begin
      halt_q <= 1'b0; // [R12]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      load_q <= 1'b0;
    end else if (wr_ctl) begin
      load_q <= writedata[`BCC_BIT_LOAD];
    end else if (load_q) begin
      load_q <= 1'b0; // [R12]
    end
  end

  // round acts once while running, then clears; held off while halted
  always_ff @(posedge clk) begin
    if (!rstn) begin
      round_q <= 1'b0;
    end else if (wr_ctl) begin
      round_q <= writedata[`BCC_BIT_ROUND];
    end else if (do_round) begin
      round_q <= 1'b0; // [R8]
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (word_sel[0]) begin
      rd_mux[15:0] = {fld_q[F_MIN], fld_q[F_SEC]};
    end else if (word_sel[1]) begin
      rd_mux[15:0] = {fld_q[F_DAY], fld_q[F_HOUR]};
    end else if (word_sel[2]) begin
      rd_mux[15:0] = {fld_q[F_YEAR], fld_q[F_MON]};
    end else if (word_sel[3]) begin
      rd_mux[`BCC_BIT_LOAD]  = load_q;
      rd_mux[`BCC_BIT_HALT]  = halt_q;
      rd_mux[`BCC_BIT_ROUND] = round_q;
      rd_mux[7:0]            = fld_q[F_WDAY];
    end
  end // [R13]

  // captured on the first edge that samples the request, held through the answer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_q <= 32'h0000_0000;
    end else if (read && bus_q == bcc_pkg::BCC_BUS_IDLE) begin
      rdata_q <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // field outputs
  // ------------------------------------------------------------
  assign sec_bcd  = fld_q[F_SEC]; // [R13]
  assign min_bcd  = fld_q[F_MIN];
  assign hour_bcd = fld_q[F_HOUR];
  assign day_bcd  = fld_q[F_DAY];
  assign mon_bcd  = fld_q[F_MON];
  assign year_bcd = fld_q[F_YEAR];
  assign wday_bcd = fld_q[F_WDAY];
  assign halted   = halt_q;

endmodule

`default_nettype wire

// File: tb/bcc_calendar_props.sv
`default_nettype none

module bcc_calendar_props #(
  parameter int unsigned TICK_CYCLES = 4,
  parameter int unsigned ADDR_W      = 8
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              rstn,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic              read,
  input wire logic              write,
  input wire logic [31:0]       writedata,
  input wire logic [3:0]        byteenable,
  input wire logic [31:0]       readdata,
  input wire logic              waitrequest,
  // calendar fields
  input wire logic [7:0]        sec_bcd,
  input wire logic [7:0]        min_bcd,
  input wire logic [7:0]        hour_bcd,
  input wire logic [7:0]        day_bcd,
  input wire logic [7:0]        mon_bcd,
  input wire logic [7:0]        year_bcd,
  input wire logic [7:0]        wday_bcd,
  // control state
  input wire logic              halted,
  input wire logic              sec_tick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  wire logic ctl_wr = write && !waitrequest && address == ADDR_W'(8'h54) && byteenable[1];
  // a tick with no write pending is the only clean counting step
  wire logic run_tick = sec_tick && !halted && !write;

  sequence s_req; (read || write) && waitrequest; endsequence
  sequence s_ans; !waitrequest; endsequence

  property p_one_wait; s_req |=> s_ans; endproperty
  property p_freeze;
    halted && !write |=> $stable({sec_bcd, min_bcd, hour_bcd, day_bcd, mon_bcd, year_bcd, wday_bcd});
  endproperty
  property p_sec_min; sec_bcd <= 8'h59 && min_bcd <= 8'h59 && sec_bcd[3:0] <= 4'h9 && min_bcd[3:0] <= 4'h9; endproperty
  property p_hour; hour_bcd <= 8'h23 && hour_bcd[3:0] <= 4'h9; endproperty
  property p_day; day_bcd >= 8'h01 && day_bcd <= 8'h31 && day_bcd[3:0] <= 4'h9; endproperty
  property p_mon; mon_bcd >= 8'h01 && mon_bcd <= 8'h12 && mon_bcd[3:0] <= 4'h9; endproperty
  property p_year; year_bcd[7:4] <= 4'h9 && year_bcd[3:0] <= 4'h9; endproperty
  property p_wday; wday_bcd <= 8'h06; endproperty
  property p_sec_step; run_tick && sec_bcd[3:0] != 4'h9 |=> sec_bcd == $past(sec_bcd) + 8'h01; endproperty
  property p_wday_step;
    run_tick && {hour_bcd, min_bcd, sec_bcd} == 24'h235959
      |=> wday_bcd == (($past(wday_bcd) == 8'h06) ? 8'h00 : $past(wday_bcd) + 8'h01);
  endproperty
  property p_tick_gap; sec_tick |=> !sec_tick [*3]; endproperty
  property p_halt_set; ctl_wr && writedata[14] && !writedata[15] |=> halted; endproperty
  property p_load_run; ctl_wr && writedata[15] |=> ##1 !halted; endproperty

  a_one_wait: assert property (p_one_wait) else $error("bus answer not after one wait state");
  a_freeze: assert property (p_freeze) else $error("fields moved while halted");
  a_sec_min: assert property (p_sec_min) else $error("seconds or minutes out of range");
  a_hour: assert property (p_hour) else $error("hour out of range");
  a_day: assert property (p_day) else $error("day out of range");
  a_mon: assert property (p_mon) else $error("month out of range");
  a_year: assert property (p_year) else $error("year not bcd");
  a_wday: assert property (p_wday) else $error("weekday out of range");
  a_sec_step: assert property (p_sec_step) else $error("seconds did not step");
  a_wday_step: assert property (p_wday_step) else $error("weekday did not step at midnight");
  a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
  a_halt_set: assert property (p_halt_set) else $error("halt not taken");
  a_load_run: assert property (p_load_run) else $error("load did not release halt");
endmodule

bind bcc_calendar bcc_calendar_props #(.TICK_CYCLES(TICK_CYCLES), .ADDR_W(ADDR_W)) i_props (
  .clk, .rstn, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .sec_bcd,
  .min_bcd, .hour_bcd, .day_bcd, .mon_bcd, .year_bcd, .wday_bcd, .halted, .sec_tick
);

`default_nettype wire

// File: tb/tb_top.sv
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0;
  logic [7:0]  address = 8'h00;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'h0;
  logic [31:0] readdata;
  logic        waitrequest, halted, sec_tick;
  logic [7:0]  sec_bcd, min_bcd, hour_bcd, day_bcd, mon_bcd, year_bcd, wday_bcd;
  logic [15:0] exp_q[$];
  int          fail_count = 0, comparisons = 0, cyc = 0;

  initial forever #2.5 clk = ~clk;

  bcc_calendar #(.TICK_CYCLES(4), .ADDR_W(8)) i_dut (
    .clk, .rstn, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest, .sec_bcd,
    .min_bcd, .hour_bcd, .day_bcd, .mon_bcd, .year_bcd, .wday_bcd, .halted, .sec_tick
  );

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t readdata %h expected %h", $time, g, e);
    end
  endtask

  // oldest noted read is matched against the data at its answering edge
  always @(posedge clk) begin
    if (read && waitrequest === 1'b0) begin
      chk({16'h0, exp_q.pop_front()}, readdata);
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc > 6000) begin
      fail_count++;
      $display("[ERR] %0t timeout", $time);
      end_of_test();
    end
  end

  // the extra edge at the end keeps two requests from being driven in one time step
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] be = 4'h3);
    address <= a;
    writedata <= {16'h0, d};
    byteenable <= be;
    write <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    address <= a;
    read <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    read <= 1'b0;
    @(posedge clk);
  endtask

  // load a date while halted, run exactly one tick, halt again and read it all back
  task automatic roll(input logic [15:0] w12, w13, w14, w15, e12, e13, e14, e15);
    int i;
    i = 0;
    wr(8'h54, {8'h40, w15[7:0]});
    wr(8'h48, w12);
    wr(8'h4C, w13);
    wr(8'h50, w14);
    rd(8'h48, w12);
    rd(8'h54, {8'h40, w15[7:0]});
    wr(8'h54, 16'hC000 | w15);
    while (!(sec_tick === 1'b1 && halted === 1'b0) && i < 50) begin
      @(posedge clk);
      i++;
    end
    wr(8'h54, 16'h4000, 4'h2);
    rd(8'h48, e12);
    rd(8'h4C, e13);
    rd(8'h50, e14);
    rd(8'h54, e15);
  endtask

  initial begin
    int         y;
    logic [7:0] yb;
    bit         lp;
    void'($urandom(43));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(8'h48, 16'h0000);
    rd(8'h4C, 16'h0100);
    rd(8'h50, 16'h0001);
    rd(8'h54, 16'h0000);
    rd(8'h40, 16'h0000);
    $display("test reset done");
    roll(16'h5959, 16'h3123, 16'h9912, 16'h0006, 16'h0000, 16'h0100, 16'h0001, 16'h4000);
    roll(16'h5959, 16'h3023, 16'h2404, 16'h0003, 16'h0000, 16'h0100, 16'h2405, 16'h4004);
    $display("test rollover done");
    for (int k = 0; k < 4; k++) begin
      y = $urandom_range(99);
      yb = {4'(y / 10), 4'(y % 10)};
      lp = (y % 4 == 0);
      roll(16'h5959, 16'h2823, {yb, 8'h02}, 16'h0002, 16'h0000, lp ? 16'h2900 : 16'h0100,
           {yb, lp ? 8'h02 : 8'h03}, 16'h4003);
    end
    $display("test leap done");
    roll(16'h0945, 16'h1510, 16'h2406, 16'h2001, 16'h1001, 16'h1510, 16'h2406, 16'h4001);
    roll(16'h0929, 16'h1510, 16'h2406, 16'h2001, 16'h0901, 16'h1510, 16'h2406, 16'h4001);
    roll(16'h5930, 16'h1510, 16'h2406, 16'h2001, 16'h0001, 16'h1511, 16'h2406, 16'h4001);
    $display("test round done");
    end_of_test();
  end
endmodule

`default_nettype wire
